/* File: cocr_pkg.sv */
// Package: register map, field layout and carrier types for the output config bank
package cocr_pkg;

    // Printed offsets are not all multiples of four: indices, byte address is 4x
    localparam logic [7:0] IDX_CLOCK_TRAIL = 8'h02;
    localparam logic [7:0] IDX_RAW_POS     = 8'h09;
    localparam logic [7:0] IDX_PORT0_EN    = 8'h13;
    localparam logic [7:0] IDX_PORT1_EN    = 8'h14;
    localparam logic [7:0] IDX_PASS_ROUTE  = 8'h16;
    localparam logic [7:0] IDX_VC_CTRL     = 8'h2E;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // Reset values
    localparam logic [7:0] RST_CLOCK_TRAIL = 8'h00;
    localparam logic [7:0] RST_RAW_POS     = 8'h00;
    localparam logic [7:0] RST_PORT0_EN    = 8'h3F;
    localparam logic [7:0] RST_PORT1_EN    = 8'h00;
    localparam logic [7:0] RST_PASS_ROUTE  = 8'h02;
    localparam logic [7:0] RST_VC_CTRL     = 8'h00;

    // Writable masks: reserved bits stay zero
    localparam logic [7:0] MSK_CLOCK_TRAIL = 8'h8F;
    localparam logic [7:0] MSK_RAW_POS     = 8'h10;
    localparam logic [7:0] MSK_PORT_EN     = 8'hBF;
    localparam logic [7:0] MSK_PASS_ROUTE  = 8'h06;
    localparam logic [7:0] MSK_VC_CTRL     = 8'hC0;

    // Field positions
    localparam int BIT_TRAIL_OVERRIDE = 7;
    localparam int BIT_RAW_MSB        = 4;
    localparam int BIT_REG_CTRL       = 7;
    localparam int BIT_PASS_TO_PIN3   = 2;
    localparam int BIT_PASS_TO_PIN0   = 1;
    localparam int BIT_PASS_STATE     = 0;
    localparam int VC_LSB             = 6;
    localparam int LANES_W            = 6;

    // Bus answer for unmapped reads
    localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] clock_trail;
        logic [7:0] raw_pos;
        logic [7:0] port0_en;
        logic [7:0] port1_en;
        logic [7:0] pass_route;
        logic [7:0] vc_ctrl;
    } cocr_regs_s;

    typedef struct packed {
        logic       trail_override;
        logic [3:0] trail_value;
        logic       raw_msb;
        logic [5:0] output_port0_lanes;
        logic       port0_reg_ctrl;
        logic [5:0] output_port1_lanes;
        logic       port1_reg_ctrl;
        logic       pass_to_pin3;
        logic       pass_to_pin0;
        logic [1:0] virtual_channel_select;
    } cocr_cfg_s;

    typedef struct packed {
        cocr_regs_s  regs;
        logic        rd_pend;
        logic [31:0] rdata;
        logic        pass_meta;
        logic        pass_sync;
        logic [3:0]  trail_eff;
        cocr_cfg_s   cfg;
        logic        gpio0_out;
        logic        gpio0_oe_n;
        logic        gpio3_out;
        logic        gpio3_oe_n;
    } cocr_state_s;

endpackage

/* File: cocr_regs.sv */
// Output configuration register bank with Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Override bit set: programmed 4-bit trail value is used as trail timing.
// - Override clear (reset): automatic trail value used, programmed value ignored.
// - RAW placement bit 4: zero puts RAW on LSBs, one on MSBs.
// - Port 0 lane field resets to all ones; 3F enables, 00 disables.
// - Port 1 lane field resets to zero; 3F enables, 00 disables.
// - Routing bit 2 set drives PASS onto general pin 3; resets zero.
// - Routing bit 1 set drives PASS onto general pin 0; resets one.
// - Routing bit 0 reads back the live PASS indicator.
// - Bits 7-6 of channel register pick virtual channel 0 to 3.
module cocr_regs (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic [cocr_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                         avs_read_i,
    input  wire logic                         avs_write_i,
    input  wire logic [cocr_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]                   avs_byteenable_i,
    output var  logic [cocr_pkg::DATA_W-1:0]  avs_readdata_o,
    output var  logic                         avs_waitrequest_o,
    input  wire logic                         pass_i,
    input  wire logic [3:0]                   auto_trail_i,
    output var  logic [3:0]                   trail_value_o,
    output var  cocr_pkg::cocr_cfg_s          cfg_o,
    output var  logic                         gpio0_o,
    output var  logic                         gpio0_oe_n_o,
    output var  logic                         gpio3_o,
    output var  logic                         gpio3_oe_n_o
);

    cocr_pkg::cocr_state_s state_r;
    cocr_pkg::cocr_state_s state_nxt;

    logic       word_ok;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic       wen;

    ////////////////////////////////////////////////////////////////////////
    // Address decode: only aligned words, low byte lane carries data
    assign word_ok = (avs_address_i[1:0] == 2'h0);
    assign idx     = avs_address_i[9:2];
    assign wbyte   = avs_writedata_i[7:0];
    // Writes land on the first edge; byte lane 0 must be enabled
    assign wen     = avs_write_i & word_ok & avs_byteenable_i[0];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for the whole bank
    always_comb begin
        state_nxt = state_r;

        // Two-flop synchroniser on the asynchronous PASS indicator
        state_nxt.pass_meta = pass_i;
        state_nxt.pass_sync = state_r.pass_meta;

        // Register writes; unlisted offsets are dropped silently
        if (wen) begin
            case (idx)
                cocr_pkg::IDX_CLOCK_TRAIL: begin
                    state_nxt.regs.clock_trail = wbyte & cocr_pkg::MSK_CLOCK_TRAIL;
                end
                cocr_pkg::IDX_RAW_POS: begin
                    state_nxt.regs.raw_pos = wbyte & cocr_pkg::MSK_RAW_POS;
                end
                cocr_pkg::IDX_PORT0_EN: begin
                    state_nxt.regs.port0_en = wbyte & cocr_pkg::MSK_PORT_EN;
                end
                cocr_pkg::IDX_PORT1_EN: begin
                    state_nxt.regs.port1_en = wbyte & cocr_pkg::MSK_PORT_EN;
                end
                cocr_pkg::IDX_PASS_ROUTE: begin
                    // Status bit 0 is not stored: it always mirrors PASS
                    state_nxt.regs.pass_route = wbyte & cocr_pkg::MSK_PASS_ROUTE;
                end
                cocr_pkg::IDX_VC_CTRL: begin
                    state_nxt.regs.vc_ctrl = wbyte & cocr_pkg::MSK_VC_CTRL;
                end
                default: begin
                    state_nxt.regs = state_r.regs; // Reserved offsets untouched
                end
            endcase
        end

        // Reads take one wait cycle so readdata comes from a flop
        state_nxt.rd_pend = avs_read_i & ~state_r.rd_pend;
        state_nxt.rdata   = cocr_pkg::UNMAPPED_RDATA;
        if (avs_read_i & ~state_r.rd_pend & word_ok) begin
            case (idx)
                cocr_pkg::IDX_CLOCK_TRAIL: state_nxt.rdata[7:0] = state_r.regs.clock_trail;
                cocr_pkg::IDX_RAW_POS:     state_nxt.rdata[7:0] = state_r.regs.raw_pos;
                cocr_pkg::IDX_PORT0_EN:    state_nxt.rdata[7:0] = state_r.regs.port0_en;
                cocr_pkg::IDX_PORT1_EN:    state_nxt.rdata[7:0] = state_r.regs.port1_en;
                cocr_pkg::IDX_PASS_ROUTE: begin
                    state_nxt.rdata[7:0] = state_r.regs.pass_route;
                    state_nxt.rdata[cocr_pkg::BIT_PASS_STATE] = state_r.pass_sync;
                end
                cocr_pkg::IDX_VC_CTRL:     state_nxt.rdata[7:0] = state_r.regs.vc_ctrl;
                default:                   state_nxt.rdata = cocr_pkg::UNMAPPED_RDATA;
            endcase
        end else if (state_r.rd_pend) begin
            state_nxt.rdata = state_r.rdata;
        end

        // Trail timing: override picks the programmed value, else automatic
        if (state_r.regs.clock_trail[cocr_pkg::BIT_TRAIL_OVERRIDE]) begin
            state_nxt.trail_eff = state_r.regs.clock_trail[3:0];
        end else begin
            state_nxt.trail_eff = auto_trail_i;
        end

        // Decoded configuration for the output datapath
        state_nxt.cfg.trail_override = state_r.regs.clock_trail[cocr_pkg::BIT_TRAIL_OVERRIDE];
        state_nxt.cfg.trail_value    = state_r.regs.clock_trail[3:0];
        state_nxt.cfg.raw_msb        = state_r.regs.raw_pos[cocr_pkg::BIT_RAW_MSB];
        state_nxt.cfg.output_port0_lanes = state_r.regs.port0_en[cocr_pkg::LANES_W-1:0];
        state_nxt.cfg.port0_reg_ctrl = state_r.regs.port0_en[cocr_pkg::BIT_REG_CTRL];
        state_nxt.cfg.output_port1_lanes = state_r.regs.port1_en[cocr_pkg::LANES_W-1:0];
        state_nxt.cfg.port1_reg_ctrl = state_r.regs.port1_en[cocr_pkg::BIT_REG_CTRL];
        state_nxt.cfg.pass_to_pin3   = state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN3];
        state_nxt.cfg.pass_to_pin0   = state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN0];
        state_nxt.cfg.virtual_channel_select = state_r.regs.vc_ctrl[7:cocr_pkg::VC_LSB];

        // PASS routing onto general pins; enable low while driving
        state_nxt.gpio3_out  = state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN3]
                               & state_r.pass_sync;
        state_nxt.gpio3_oe_n = ~state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN3];
        state_nxt.gpio0_out  = state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN0]
                               & state_r.pass_sync;
        state_nxt.gpio0_oe_n = ~state_r.regs.pass_route[cocr_pkg::BIT_PASS_TO_PIN0];
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; decoded outputs trail the bank by one cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r                  <= '0;
            state_r.regs.clock_trail <= cocr_pkg::RST_CLOCK_TRAIL;
            state_r.regs.raw_pos     <= cocr_pkg::RST_RAW_POS;
            state_r.regs.port0_en    <= cocr_pkg::RST_PORT0_EN;
            state_r.regs.port1_en    <= cocr_pkg::RST_PORT1_EN;
            state_r.regs.pass_route  <= cocr_pkg::RST_PASS_ROUTE;
            state_r.regs.vc_ctrl     <= cocr_pkg::RST_VC_CTRL;
            state_r.cfg.output_port0_lanes <= 6'h3F;
            state_r.cfg.pass_to_pin0 <= 1'b1;
            state_r.gpio0_oe_n       <= 1'b0;
            state_r.gpio3_oe_n       <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops, except waitrequest, which is gated by avs_read_i; it is high until the read answers
    assign avs_readdata_o    = state_r.rdata;
    assign avs_waitrequest_o = avs_read_i & ~state_r.rd_pend;
    assign trail_value_o     = state_r.trail_eff;
    assign cfg_o             = state_r.cfg;
    assign gpio0_o           = state_r.gpio0_out;
    assign gpio0_oe_n_o      = state_r.gpio0_oe_n;
    assign gpio3_o           = state_r.gpio3_out;
    assign gpio3_oe_n_o      = state_r.gpio3_oe_n;

endmodule

`default_nettype wire

/* File: cocr_far_model.sv */
// Far-side model: link status source feeding PASS and the automatic trail value
`timescale 1ns/1ps
`default_nettype none
module cocr_far_model #(
    parameter logic [3:0] AUTO_TRAIL = 4'hA
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       lock_i,
    output var  logic       pass_o,
    output var  logic [3:0] auto_trail_o
);
    // Link lock shows on PASS one cycle late, like a registered status
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) pass_o <= 1'b0;
        else pass_o <= lock_i;
    end
    assign auto_trail_o = AUTO_TRAIL;
endmodule
`default_nettype wire

/* File: cocr_monitor.sv */
// Checker: field decode and PASS routing assertions for the output config bank
`timescale 1ns/1ps
`default_nettype none
module cocr_monitor (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic [cocr_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic                        avs_read_i,
    input wire logic                        avs_write_i,
    input wire logic [cocr_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0]                  avs_byteenable_i,
    input wire logic [cocr_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic                        avs_waitrequest_o,
    input wire logic                        pass_i,
    input wire logic [3:0]                  auto_trail_i,
    input wire logic [3:0]                  trail_value_o,
    input wire cocr_pkg::cocr_cfg_s         cfg_o,
    input wire logic                        gpio0_o,
    input wire logic                        gpio0_oe_n_o,
    input wire logic                        gpio3_o,
    input wire logic                        gpio3_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Accepted write to one index; PASS quiet long enough to pass the synchroniser
    sequence s_wr(logic [9:0] a);
        avs_write_i && avs_byteenable_i[0] && avs_address_i == a;
    endsequence
    sequence s_pass_held;
        $stable(pass_i)[*5];
    endsequence
    AST_TRAIL_OVR: assert property (
        cfg_o.trail_override |-> trail_value_o == cfg_o.trail_value)
        else $error("trail output differs from programmed value");
    AST_TRAIL_AUTO: assert property (
        !cfg_o.trail_override && $past(rst_n_i) |-> trail_value_o == $past(auto_trail_i))
        else $error("trail output differs from automatic value");
    AST_RAW: assert property (
        s_wr({cocr_pkg::IDX_RAW_POS, 2'b00})
        |=> ##1 cfg_o.raw_msb == $past(avs_writedata_i[4], 2))
        else $error("raw placement not decoded");
    AST_PORT0: assert property (
        s_wr({cocr_pkg::IDX_PORT0_EN, 2'b00})
        |=> ##1 cfg_o.output_port0_lanes == $past(avs_writedata_i[5:0], 2))
        else $error("port 0 lanes not decoded");
    AST_PORT1: assert property (
        s_wr({cocr_pkg::IDX_PORT1_EN, 2'b00})
        |=> ##1 cfg_o.output_port1_lanes == $past(avs_writedata_i[5:0], 2))
        else $error("port 1 lanes not decoded");
    AST_VC: assert property (
        s_wr({cocr_pkg::IDX_VC_CTRL, 2'b00})
        |=> ##1 cfg_o.virtual_channel_select == $past(avs_writedata_i[7:6], 2))
        else $error("virtual channel not decoded");
    AST_PIN3_OFF: assert property (
        !cfg_o.pass_to_pin3 |-> gpio3_oe_n_o && !gpio3_o)
        else $error("pin 3 driven while not routed");
    AST_PIN0_ON: assert property (
        s_pass_held ##0 cfg_o.pass_to_pin0 |-> !gpio0_oe_n_o && gpio0_o == pass_i)
        else $error("pin 0 not carrying PASS");
    AST_PASS_RD: assert property (
        s_pass_held ##0 avs_read_i && !avs_waitrequest_o
        && avs_address_i == {cocr_pkg::IDX_PASS_ROUTE, 2'b00}
        |-> avs_readdata_o[0] == pass_i)
        else $error("PASS status bit wrong on read");
endmodule
bind cocr_regs cocr_monitor u_mon (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pass_i, .auto_trail_i,
    .trail_value_o, .cfg_o, .gpio0_o, .gpio0_oe_n_o, .gpio3_o, .gpio3_oe_n_o);
`default_nettype wire

/* File: cocr_regs_tb_top.sv */
// Testbench: register bank scenarios over the Avalon slave port
`timescale 1ns/1ps
`default_nettype none
module cocr_regs_tb_top;
    localparam logic [3:0] AUTO = 4'hA;
    logic clk_i = 1'b0, rst_n_i = 1'b0, rd = 1'b0, wr = 1'b0, lock = 1'b0;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] be = 4'hF, auto_t, tval;
    logic wreq, pass, g0, g0n, g3, g3n;
    cocr_pkg::cocr_cfg_s cfg;
    int failures = 0, n_compared = 0, cyc = 0;
    always #20 clk_i = ~clk_i;
    cocr_far_model #(.AUTO_TRAIL(AUTO)) FAR (.clk_i, .rst_n_i, .lock_i(lock), .pass_o(pass),
        .auto_trail_o(auto_t));
    cocr_regs DUT (.clk_i, .rst_n_i, .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .pass_i(pass), .auto_trail_i(auto_t), .trail_value_o(tval),
        .cfg_o(cfg), .gpio0_o(g0), .gpio0_oe_n_o(g0n), .gpio3_o(g3), .gpio3_oe_n_o(g3n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Request rises after an edge and holds until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        wr <= w;
        rd <= !w;
        do begin
            @(posedge clk_i);
        end while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        chk(nm, {24'h0, e}, q);
    endtask
    task automatic settle;
        repeat (6) @(negedge clk_i);
    endtask
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc("trail", cocr_pkg::IDX_CLOCK_TRAIL, 8'h00);
        rdc("raw", cocr_pkg::IDX_RAW_POS, 8'h00);
        rdc("port0", cocr_pkg::IDX_PORT0_EN, 8'h3F);
        rdc("port1", cocr_pkg::IDX_PORT1_EN, 8'h00);
        rdc("route", cocr_pkg::IDX_PASS_ROUTE, 8'h02);
        rdc("vc", cocr_pkg::IDX_VC_CTRL, 8'h00);
        chk("pin3 oe_n", 1, g3n);
        chk("raw msb0", 0, cfg.raw_msb);
    endtask
    // Override on, reserved bits dropped, then back to the automatic value
    task automatic t_trail;
        bus(1'b1, cocr_pkg::IDX_CLOCK_TRAIL, 8'hF5);
        settle();
        chk("trail ovr", 5, tval);
        rdc("trail rsvd", cocr_pkg::IDX_CLOCK_TRAIL, 8'h85);
        bus(1'b1, cocr_pkg::IDX_CLOCK_TRAIL, 8'h05);
        settle();
        chk("trail auto", AUTO, tval);
    endtask
    task automatic t_fields;
        bus(1'b1, cocr_pkg::IDX_RAW_POS, 8'hFF);
        bus(1'b1, cocr_pkg::IDX_PORT0_EN, 8'h00);
        bus(1'b1, cocr_pkg::IDX_PORT1_EN, 8'h3F);
        settle();
        chk("raw msb", 1, cfg.raw_msb);
        rdc("raw rsvd", cocr_pkg::IDX_RAW_POS, 8'h10);
        chk("p0 lanes", 0, cfg.output_port0_lanes);
        chk("p1 lanes", 8'h3F, cfg.output_port1_lanes);
        for (int v = 0; v < 4; v++) begin
            bus(1'b1, cocr_pkg::IDX_VC_CTRL, 8'(v << 6));
            settle();
            chk("vc", v, cfg.virtual_channel_select);
        end
    endtask
    // Status bit is read-only: written zero, PASS high must read one
    task automatic t_pass;
        lock <= 1'b1;
        bus(1'b1, cocr_pkg::IDX_PASS_ROUTE, 8'h04);
        settle();
        chk("pin3", 2'b01, {g3n, g3});
        chk("pin0 off", 2'b10, {g0n, g0});
        rdc("route", cocr_pkg::IDX_PASS_ROUTE, 8'h05);
        bus(1'b1, cocr_pkg::IDX_PASS_ROUTE, 8'h03);
        settle();
        chk("pin0 high", 2'b01, {g0n, g0});
        lock <= 1'b0;
        settle();
        chk("pin0 low", 2'b00, {g0n, g0});
        rdc("route", cocr_pkg::IDX_PASS_ROUTE, 8'h02);
    endtask
    // Lane-0 disabled write leaves nothing behind; undefined offsets are only read
    task automatic t_refuse;
        be <= 4'h0;
        bus(1'b1, cocr_pkg::IDX_VC_CTRL, 8'h40);
        be <= 4'hF;
        rdc("be off", cocr_pkg::IDX_VC_CTRL, 8'hC0);
        rdc("unmapped", 8'h03, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Cut a hang short well past the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_trail();
        t_fields();
        t_pass();
        t_refuse();
        end_sim();
    end
endmodule
`default_nettype wire
